/* File: tb/metering_event_output_pins_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module metering_event_output_pins_tb;
    localparam MS_CYCLES = 10; // short tick keeps the run brief
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [1:0] mode_req = 2'h0;
    reg acc = 1'b0; // host config access in progress
    wire cs_n;
    reg [15:0] es1 = 16'h0000;
    reg [15:0] es2 = 16'h0000;
    reg [1:0] cdet = 2'h0;
    reg cks = 1'b0;
    reg [15:0] zxc = 16'h6160; // a: volt A rise, b: curr A fall, c: off
    reg [15:0] mm = 16'h0000;
    reg [5:0] sgn = 6'h08;
    reg [4:0] evt = 5'h00; // active, reactive, apparent, fund, harm
    wire pin_lo, pin_hi, l1, l2, warn;
    wire [1:0] pm;
    wire [6:0] outs; // four energy pulses, then three crossings
    integer miscompares = 0;
    integer samples_checked = 0;
    integer i, w;
    mevo_host i_mevo_host (.core_clk_i(clk), .mode_req_i(mode_req), .access_i(acc),
        .power_mode_pin_low_o(pin_lo), .power_mode_pin_high_o(pin_hi),
        .chip_select_n_o(cs_n));
    mevo_pins #(.MS_CYCLES(MS_CYCLES)) i_mevo_pins (.core_clk_i(clk), .arst_n_i(rst_n),
        .power_mode_pin_low_i(pin_lo), .power_mode_pin_high_i(pin_hi),
        .event_state_first_i(es1), .event_state_second_i(es2), .current_detect_i(cdet),
        .checksum_err_i(cks), .zero_crossing_config_i(zxc), .metering_mode_first_i(mm),
        .phase_sign_i(sgn), .active_evt_i(evt[0]), .reactive_evt_i(evt[1]),
        .apparent_evt_i(evt[2]), .fundamental_evt_i(evt[3]), .harmonic_evt_i(evt[4]),
        .power_mode_o(pm), .event_line_first_o(l1), .event_line_second_o(l2),
        .fatal_warning_line_o(warn), .zero_cross_out_a_o(outs[4]),
        .zero_cross_out_b_o(outs[5]), .zero_cross_out_c_o(outs[6]),
        .active_pulse_out_o(outs[0]), .reactive_apparent_pulse_out_o(outs[1]),
        .fundamental_pulse_out_o(outs[2]), .harmonic_pulse_out_o(outs[3]));
    initial begin
        forever #10 clk = ~clk;
    end
    task complete_run;
        if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task check(input string nm, input [15:0] seen, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait for a pin level; n returns cycles spent
    task wait_pin(input integer k, input v, input integer lim, output integer n);
        n = 0;
        while (outs[k] !== v && n < lim) begin
            step(1);
            n = n + 1;
        end
        if (outs[k] !== v) check("pin wait", 0, 1);
        if (outs[k] !== v) complete_run;
    endtask
    task set_mode(input [1:0] m);
        integer n;
        n = 0;
        mode_req = m;
        while (pm !== m && n < 12) begin
            step(1);
            n = n + 1;
        end
        check("mode", pm, m);
        if (pm !== m) complete_run;
    endtask
    task fire(input integer j);
        evt = 5'h01 << j;
        step(1);
        evt = 5'h00;
    endtask
    initial begin
        step(10);
        rst_n = 1'b1;
        step(1);
        check("after reset", {pm, warn, l2, l1, outs}, 0);
        set_mode(2'h3);
        es1 = 16'h0100;
        step(2);
        check("lines", {l2, l1}, 2'b01);
        es1 = 16'h0000;
        es2 = 16'h8000;
        cks = 1'b1;
        step(2);
        check("lines warn", {warn, l2, l1}, 3'b110);
        es2 = 16'h0000;
        cks = 1'b0;
        step(2);
        check("lines warn", {warn, l2, l1}, 0);
        // i 5 is apparent with the select clear: no pulse
        for (i = 0; i < 6; i = i + 1) begin
            // mode register changes only inside a chip-select frame
            acc = 1'b1;
            step(1);
            mm = (i == 2) ? 16'h0080 : 16'h0000;
            acc = 1'b0;
            fire(i == 5 ? 2 : i);
            check("pulse pins", outs, i == 5 ? 0 : 1 << (i - (i > 1)));
            wait_pin(i == 5 ? 1 : i - (i > 1), 1'b0, 2000, w);
            if (i == 0) check("long width", w > 780 && w < 820, 1);
        end
        fire(0);
        wait_pin(0, 1'b0, 2000, w);
        step(999 - w);
        fire(0);
        wait_pin(0, 1'b0, 2000, w);
        check("half width", w > 480 && w < 520, 1);
        sgn = 6'h09;
        wait_pin(4, 1'b1, 8, w);
        check("crossing", outs[6:4], 3'b001);
        wait_pin(4, 1'b0, 80, w);
        check("crossing width", w > 35 && w < 52, 1);
        sgn = 6'h01;
        wait_pin(5, 1'b1, 8, w);
        check("crossing", outs[6:4], 3'b010);
        es1 = 16'h0001;
        set_mode(2'h2);
        step(2);
        check("partial", l1, 1);
        set_mode(2'h1);
        check("enter detect", {l2, l1}, 0);
        step(5);
        check("detect", {l2, l1}, 0);
        cdet = 2'h2;
        cks = 1'b1;
        step(5);
        check("detect", {warn, l2, l1}, 3'b010);
        // detector still high, so only the clear can drop the lines here
        set_mode(2'h3);
        check("leave detect", {l2, l1}, 0);
        cdet = 2'h0;
        step(2);
        check("normal again", {warn, l2, l1}, 3'b101);
        set_mode(2'h0);
        step(2);
        check("idle", {warn, l2, l1}, 0);
        set_mode(2'h3);
        step(2);
        rst_n = 1'b0;
        step(3);
        check("mid reset", {pm, warn, l2, l1, outs}, 0);
        rst_n = 1'b1;
        step(1);
        check("reset release", {pm, warn, l2, l1, outs}, 0);
        set_mode(2'h3);
        complete_run;
    end
endmodule // metering_event_output_pins_tb
bind mevo_pins mevo_pins_props #(.MS_CYCLES(MS_CYCLES)) i_mevo_pins_props (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .event_state_first_i(event_state_first_i),
    .event_state_second_i(event_state_second_i),
    .checksum_err_i(checksum_err_i),
    .metering_mode_first_i(metering_mode_first_i),
    .active_evt_i(active_evt_i),
    .apparent_evt_i(apparent_evt_i),
    .power_mode_o(power_mode_o),
    .event_line_first_o(event_line_first_o),
    .event_line_second_o(event_line_second_o),
    .fatal_warning_line_o(fatal_warning_line_o),
    .active_pulse_out_o(active_pulse_out_o),
    .reactive_apparent_pulse_out_o(reactive_apparent_pulse_out_o),
    .harmonic_pulse_out_o(harmonic_pulse_out_o)
);
`default_nettype wire

/* File: tb/mevo_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// host side: power mode pins
// ------------------------------
module mevo_host (
    input wire core_clk_i,
    input wire [1:0] mode_req_i,
    input wire access_i,
    output reg power_mode_pin_low_o = 1'b0,
    output reg power_mode_pin_high_o = 1'b0,
    output reg chip_select_n_o = 1'b1
);
    // strapped levels move only just after an edge
    always @(posedge core_clk_i) begin
        {power_mode_pin_high_o, power_mode_pin_low_o} <= mode_req_i;
        // falls as each config access starts, stays low until it ends
        chip_select_n_o <= ~access_i;
    end
endmodule // mevo_host
`default_nettype wire

/* File: tb/mevo_pins_props.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// output pin checker
// ------------------------------
module mevo_pins_props #(
    parameter MS_CYCLES = 10
) (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire [15:0] event_state_first_i,
    input wire [15:0] event_state_second_i,
    input wire checksum_err_i,
    input wire [15:0] metering_mode_first_i,
    input wire active_evt_i,
    input wire apparent_evt_i,
    input wire [1:0] power_mode_o,
    input wire event_line_first_o,
    input wire event_line_second_o,
    input wire fatal_warning_line_o,
    input wire active_pulse_out_o,
    input wire reactive_apparent_pulse_out_o,
    input wire harmonic_pulse_out_o
);
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    localparam int LIM = 82 * MS_CYCLES; // 80 ms plus tick slack
    wire nrm = power_mode_o == 2'h3; // normal mode
    wire dtc = power_mode_o == 2'h1; // detection mode
    reg [31:0] hi_q; // cycles the harmonic pulse stood high
    // restarting pulses could stretch this; bench never does so
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_q <= 32'h0;
        end else begin
            hi_q <= harmonic_pulse_out_o ? hi_q + 32'h1 : 32'h0;
        end
    end
    a_first_line_follow: assert property (nrm && $past(nrm) |->
        event_line_first_o == $past(|event_state_first_i)) else $error("first line wrong");
    a_second_line_follow: assert property (nrm && $past(nrm) |->
        event_line_second_o == $past(|event_state_second_i)) else $error("second line wrong");
    a_detect_edge_clear: assert property (dtc != $past(dtc) |->
        !event_line_first_o && !event_line_second_o) else $error("lines not cleared");
    a_idle_all_quiet: assert property (power_mode_o == 2'h0 && $past(power_mode_o) == 2'h0
        |-> !(event_line_first_o || event_line_second_o || fatal_warning_line_o))
        else $error("idle outputs active");
    a_warn_follow: assert property (nrm && $past(nrm) |->
        fatal_warning_line_o == $past(checksum_err_i)) else $error("warning wrong");
    a_active_pulse_start: assert property (nrm && active_evt_i |=>
        active_pulse_out_o) else $error("active pulse missing");
    a_two_apparent: assert property (nrm && metering_mode_first_i[7] && apparent_evt_i
        |=> reactive_apparent_pulse_out_o) else $error("apparent pulse missing");
    a_pulse_width_cap: assert property (hi_q <= LIM) else $error("pulse too long");
    c_first_line: cover property (nrm && event_line_first_o);
    c_apparent: cover property (nrm && metering_mode_first_i[7] && apparent_evt_i);
    c_warning: cover property (fatal_warning_line_o);
endmodule // mevo_pins_props
`default_nettype wire

/* File: verilog/mevo_map.vh */
`ifndef MEVO_MAP_VH
`define MEVO_MAP_VH
// ----------------------------------------
// register offsets (register index)
// ----------------------------------------
`define MEVO_ZX_CONFIG_OFS 16'h0007
`define MEVO_EVT_STATE_FIRST_OFS 16'h01cc
`define MEVO_EVT_STATE_SECOND_OFS 16'h01d0
// ----------------------------------------
// field positions
// ----------------------------------------
`define MEVO_MMODE_PULSE_TWO_BIT 7
// zero-crossing config: 5 bits per output, source [2:0], mode [4:3]
`define MEVO_ZX_FIELD_W 5
`define MEVO_ZX_ALL_OFF_BIT 15
// zero-crossing modes
`define MEVO_ZX_MODE_RISE 2'h0
`define MEVO_ZX_MODE_FALL 2'h1
`define MEVO_ZX_MODE_BOTH 2'h2
`define MEVO_ZX_MODE_OFF 2'h3
// ----------------------------------------
// power mode pin encodings {high, low}
// ----------------------------------------
`define MEVO_PM_IDLE 2'h0
`define MEVO_PM_DETECT 2'h1
`define MEVO_PM_PARTIAL 2'h2
`define MEVO_PM_NORMAL 2'h3
`define MEVO_PM_RESET 2'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define MEVO_CLK_HZ 50000000
`define MEVO_MS_CYCLES (`MEVO_CLK_HZ / 1000)
`define MEVO_PULSE_MS 80
`define MEVO_LONG_PERIOD_MS 160
`define MEVO_ZX_PULSE_MS 5
`endif

/* File: verilog/mevo_pins.v */
// Notes on behaviour
// - first event line follows any first-state bit
// - second event line follows any second-state bit
// - detection mode: event lines show current detector
// - event lines cleared entering and leaving detection
// - warning line high only on checksum error
// - mode bit picks reactive or apparent pulse source
// - active, fundamental, harmonic pulses on fixed outputs
// - zero-crossing outputs per configured source and mode
// - power-mode pins select the operating mode
// - idle and detection drop logic context
// - pulse high 80 ms, or half short periods
`timescale 1ns/100ps
`default_nettype none
`include "mevo_map.vh"

module mevo_pins #(
    parameter MS_CYCLES = `MEVO_MS_CYCLES, // cycles per ms tick
    parameter PULSE_MS = `MEVO_PULSE_MS,
    parameter LONG_MS = `MEVO_LONG_PERIOD_MS,
    parameter ZX_MS = `MEVO_ZX_PULSE_MS
) (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire power_mode_pin_low_i,
    input wire power_mode_pin_high_i,
    input wire [15:0] event_state_first_i,
    input wire [15:0] event_state_second_i,
    input wire [1:0] current_detect_i,
    input wire checksum_err_i,
    input wire [15:0] zero_crossing_config_i,
    input wire [15:0] metering_mode_first_i,
    input wire [5:0] phase_sign_i,
    input wire active_evt_i,
    input wire reactive_evt_i,
    input wire apparent_evt_i,
    input wire fundamental_evt_i,
    input wire harmonic_evt_i,
    output wire [1:0] power_mode_o,
    output wire event_line_first_o,
    output wire event_line_second_o,
    output wire fatal_warning_line_o,
    output wire zero_cross_out_a_o,
    output wire zero_cross_out_b_o,
    output wire zero_cross_out_c_o,
    output wire active_pulse_out_o,
    output wire reactive_apparent_pulse_out_o,
    output wire fundamental_pulse_out_o,
    output wire harmonic_pulse_out_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // high time in ms for a measured period in ms
    function [7:0] mevo_width;
        input [7:0] period;
        begin
            if (period >= LONG_MS[7:0]) begin
                mevo_width = PULSE_MS[7:0];
            end else if (period[7:1] == 7'h00) begin
                mevo_width = 8'h01; // never shorter than one tick
            end else begin
                mevo_width = {1'b0, period[7:1]};
            end
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [1:0] pm_meta_q;
    reg [1:0] pm_q;
    reg [1:0] det_meta_q;
    reg [1:0] det_q;
    reg [5:0] sign_meta_q;
    reg [5:0] sign_q;
    reg [5:0] sign_old_q;

    // two flops each; mode pins, detector and comparators are async
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pm_meta_q <= `MEVO_PM_RESET;
            pm_q <= `MEVO_PM_RESET;
            det_meta_q <= 2'h0;
            det_q <= 2'h0;
            sign_meta_q <= 6'h00;
            sign_q <= 6'h00;
            sign_old_q <= 6'h00;
        end else begin
            pm_meta_q <= {power_mode_pin_high_i, power_mode_pin_low_i};
            pm_q <= pm_meta_q;
            det_meta_q <= current_detect_i;
            det_q <= det_meta_q;
            sign_meta_q <= phase_sign_i;
            sign_q <= sign_meta_q;
            sign_old_q <= sign_q;
        end
    end

    // ----------------------------------------
    // power mode tracking
    // ----------------------------------------
    reg [1:0] mode_q;
    wire in_det = (mode_q == `MEVO_PM_DETECT);
    wire to_det = (pm_q == `MEVO_PM_DETECT);
    wire det_edge = (in_det != to_det); // entering or leaving
    // logic unpowered in idle and detection: context is lost
    wire logic_off = (mode_q == `MEVO_PM_IDLE) || in_det;

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= `MEVO_PM_RESET;
        end else begin
            mode_q <= pm_q;
        end
    end
    assign power_mode_o = mode_q;

    // ----------------------------------------
    // event lines and warning
    // ----------------------------------------
    reg event_line_first_q;
    reg event_line_second_q;
    reg warn_q;

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            event_line_first_q <= 1'b0;
            event_line_second_q <= 1'b0;
            warn_q <= 1'b0;
        end else begin
            if (det_edge) begin
                // cleared on both mode boundaries
                event_line_first_q <= 1'b0;
                event_line_second_q <= 1'b0;
            end else if (in_det) begin
                event_line_first_q <= det_q[0];
                event_line_second_q <= det_q[1];
            end else if (logic_off) begin
                event_line_first_q <= 1'b0; // idle: no context
                event_line_second_q <= 1'b0;
            end else begin
                event_line_first_q <= |event_state_first_i;
                event_line_second_q <= |event_state_second_i;
            end
            warn_q <= checksum_err_i & ~logic_off;
        end
    end
    assign event_line_first_o = event_line_first_q;
    assign event_line_second_o = event_line_second_q;
    assign fatal_warning_line_o = warn_q;

    // ----------------------------------------
    // millisecond tick
    // ----------------------------------------
    reg [31:0] ms_cnt_q;
    wire ms_tick = (ms_cnt_q == MS_CYCLES - 1);

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ms_cnt_q <= 32'h0;
        end else if (ms_tick) begin
            ms_cnt_q <= 32'h0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h1;
        end
    end

    // ----------------------------------------
    // energy pulse shapers
    // ----------------------------------------
    wire [3:0] evt;
    wire [3:0] pulse;
    assign evt[0] = active_evt_i;
    // source chosen by the pulse-two select bit
    assign evt[1] = metering_mode_first_i[`MEVO_MMODE_PULSE_TWO_BIT] ?
        apparent_evt_i : reactive_evt_i;
    assign evt[2] = fundamental_evt_i;
    assign evt[3] = harmonic_evt_i;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cf
            reg [7:0] period_q; // ms since last event, saturating
            reg [7:0] width_q; // ms of high time left
            reg out_q;
            always @(posedge core_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    period_q <= 8'hff;
                    width_q <= 8'h00;
                    out_q <= 1'b0;
                end else if (logic_off) begin
                    period_q <= 8'hff;
                    width_q <= 8'h00;
                    out_q <= 1'b0;
                end else if (evt[g]) begin
                    // width from the period just ended
                    width_q <= mevo_width(period_q);
                    period_q <= 8'h00;
                    out_q <= 1'b1;
                end else if (ms_tick) begin
                    if (period_q != 8'hff) begin
                        period_q <= period_q + 8'h01;
                    end
                    if (width_q == 8'h01) begin
                        out_q <= 1'b0;
                    end
                    if (width_q != 8'h00) begin
                        width_q <= width_q - 8'h01;
                    end
                end
            end
            assign pulse[g] = out_q;
        end
    endgenerate

    assign active_pulse_out_o = pulse[0];
    assign reactive_apparent_pulse_out_o = pulse[1];
    assign fundamental_pulse_out_o = pulse[2];
    assign harmonic_pulse_out_o = pulse[3];

    // ----------------------------------------
    // zero-crossing outputs
    // ----------------------------------------
    wire [5:0] rise = sign_q & ~sign_old_q;
    wire [5:0] fall = ~sign_q & sign_old_q;
    wire [2:0] zx;

    generate
        for (g = 0; g < 3; g = g + 1) begin : g_zx
            wire [2:0] src = zero_crossing_config_i[g*`MEVO_ZX_FIELD_W +: 3];
            wire [1:0] mode = zero_crossing_config_i[g*`MEVO_ZX_FIELD_W + 3 +: 2];
            // sources 6 and 7 do not exist and never fire
            wire src_ok = (src < 3'h6);
            wire r = src_ok & rise[src];
            wire f = src_ok & fall[src];
            reg hit;
            reg [7:0] left_q;
            reg out_q;
            always @* begin
                case (mode)
                    `MEVO_ZX_MODE_RISE: hit = r;
                    `MEVO_ZX_MODE_FALL: hit = f;
                    `MEVO_ZX_MODE_BOTH: hit = r | f;
                    default: hit = 1'b0;
                endcase
            end
            always @(posedge core_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    left_q <= 8'h00;
                    out_q <= 1'b0;
                end else if (logic_off || zero_crossing_config_i[`MEVO_ZX_ALL_OFF_BIT]) begin
                    left_q <= 8'h00;
                    out_q <= 1'b0;
                end else if (hit) begin
                    left_q <= ZX_MS[7:0];
                    out_q <= 1'b1;
                end else if (ms_tick && left_q != 8'h00) begin
                    left_q <= left_q - 8'h01;
                    if (left_q == 8'h01) begin
                        out_q <= 1'b0;
                    end
                end
            end
            assign zx[g] = out_q;
        end
    endgenerate

    assign zero_cross_out_a_o = zx[0];
    assign zero_cross_out_b_o = zx[1];
    assign zero_cross_out_c_o = zx[2];

endmodule // mevo_pins
`default_nettype wire
